// ### sim/custom_logic_unit_tb.sv
// Self-checking bench of the custom logic unit
`timescale 1ns/10ps
module custom_logic_unit_tb;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pins;
  logic [1:0]  events;
  logic [4:0]  periph;
  logic [5:0]  pin_lv;
  logic [1:0]  ev_lv;
  logic [4:0]  per_lv;
  logic [1:0]  table_output_pin;
  logic [1:0]  event_out;
  logic [31:0] rdv;
  logic        erv;
  int          fails;
  int          n_compared;

  custom_logic_unit i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .table_input_pins(pins), .event_in(events), .peripheral_in(periph),
    .table_output_pin(table_output_pin), .event_out(event_out));
  far_side i_far (.clk(clk), .reset_n(reset_n), .pin_lv(pin_lv), .ev_lv(ev_lv),
    .per_lv(per_lv), .pins(pins), .events(events), .periph(periph));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; held until pready, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // Park the even table, set sources and truth, then the first control
  task automatic cfg(input logic [7:0] b, input logic [7:0] f, input logic [7:0] s01,
                     input logic [3:0] s2, input logic [7:0] tt);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, b + 8'h04, {24'h0, s01});
    apb(1'b1, b + 8'h08, {28'h0, s2});
    apb(1'b1, b + 8'h0c, {24'h0, tt});
    apb(1'b1, b, {24'h0, f});
  endtask

  task automatic drv(input logic [3:0] s, input logic v);
    case (s)
      4'd3: ev_lv[0] <= v;
      4'd4: ev_lv[1] <= v;
      4'd5: pin_lv[0] <= v;
      default: per_lv[s - 4'd6] <= v;
    endcase
    settle();
  endtask

  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk("global", 32'h0, rdv);
    apb(1'b0, 8'h2c, 32'h0);
    chk("truth1", {24'h0, logic_unit_pkg::TRUTH_RESET}, rdv);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, erv});
  endtask

  task automatic t_protect();
    apb(1'b1, 8'h00, 32'h1);
    cfg(8'h10, 8'h41, 8'h06, 4'h0, 8'haa);
    apb(1'b1, 8'h14, 32'h7);
    apb(1'b0, 8'h14, 32'h0);
    chk("source lock", 32'h6, rdv);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("sequencer lock", 32'h0, rdv);
    apb(1'b1, 8'h10, 32'h20);
    apb(1'b0, 8'h10, 32'h0);
    chk("clear write", 32'h40, rdv);
    apb(1'b1, 8'h10, 32'h51);
    apb(1'b0, 8'h10, 32'h0);
    chk("set write", 32'h51, rdv);
  endtask

  task automatic t_src();
    for (int s = 3; s <= 10; s++) begin
      cfg(8'h10, 8'h41, 8'(s), 4'h0, 8'haa);
      drv(4'(s), 1'b1);
      chk("source high", 32'h3, {30'h0, table_output_pin[0], event_out[0]});
      drv(4'(s), 1'b0);
      chk("source low", 32'h0, {30'h0, table_output_pin[0], event_out[0]});
    end
  endtask

  task automatic t_truth();
    logic [7:0] tt [2];
    tt = '{8'h42, 8'hb1};
    foreach (tt[j]) begin
      cfg(8'h10, 8'h01, 8'h76, 4'h8, tt[j]);
      for (int k = 0; k < 8; k++) begin
        per_lv[2:0] <= 3'(k);
        settle();
        chk("truth", 32'(tt[j][k]), 32'(event_out[0]));
      end
    end
    cfg(8'h10, 8'h01, 8'h06, 4'h8, 8'h04);
    per_lv[2:0] <= 3'b010;
    settle();
    chk("masked", 32'h0, 32'(event_out[0]));
    apb(1'b1, 8'h00, 32'h0);
    cfg(8'h10, 8'h03, 8'h76, 4'h8, 8'hf0);
    apb(1'b1, 8'h00, 32'h1);
    per_lv[2:0] <= 3'b100;
    settle();
    chk("clock input low", 32'h0, 32'(event_out[0]));
    per_lv[2:0] <= 3'b000;
    cfg(8'h10, 8'h13, 8'h06, 4'h8, 8'haa);
    drv(4'd6, 1'b1);
    chk("no clock edge", 32'h0, 32'(event_out[0]));
    repeat (2) begin
      drv(4'd8, 1'b1);
      drv(4'd8, 1'b0);
    end
    chk("clock edges", 32'h1, 32'(event_out[0]));
    per_lv[0] <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    cfg(8'h10, 8'h01, 8'h06, 4'h0, 8'haa);
    apb(1'b1, 8'h00, 32'h1);
  endtask

  task automatic lat(input logic [7:0] f, output int l, output int w);
    cfg(8'h10, f, 8'h06, 4'h0, 8'haa);
    per_lv[0] <= 1'b1;
    l = 0;
    w = 0;
    do begin
      @(posedge clk);
      l++;
    end while (event_out[0] !== 1'b1 && l < 30);
    while (event_out[0] === 1'b1 && w < 30) begin
      @(posedge clk);
      w++;
    end
    per_lv[0] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic t_filt();
    int l0;
    int l1;
    int w;
    lat(8'h01, l0, w);
    lat(8'h11, l1, w);
    chk("sync delay", 32'(l0 + 2), 32'(l1));
    lat(8'h21, l1, w);
    chk("filter delay", 32'(l0 + 4), 32'(l1));
    lat(8'h19, l1, w);
    chk("edge pulse", 32'h1, 32'(w));
  endtask

  task automatic t_glob();
    cfg(8'h10, 8'h41, 8'h06, 4'h0, 8'haa);
    drv(4'd6, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    settle();
    chk("global off", 32'h0, {28'h0, table_output_pin, event_out});
    apb(1'b1, 8'h00, 32'h1);
    settle();
    chk("global on", 32'h5, {28'h0, table_output_pin, event_out});
    apb(1'b1, 8'h10, 32'h0);
    settle();
    chk("table off", 32'h0, {28'h0, table_output_pin, event_out});
    drv(4'd6, 1'b0);
  endtask

  // Even table follows comparator, odd follows timer A; each mode ends set, set, clear
  task automatic t_seq();
    cfg(8'h20, 8'h01, 8'h07, 4'h0, 8'haa);
    cfg(8'h10, 8'h01, 8'h02, 4'h0, 8'haa);
    drv(4'd7, 1'b1);
    chk("link", 32'h3, {30'h0, event_out});
    drv(4'd7, 1'b0);
    for (int m = 1; m <= 4; m++) begin
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h04, 32'(m));
      cfg(8'h10, 8'h01, 8'h06, 4'h0, 8'haa);
      for (int i = 0; i < 3; i++) begin
        per_lv[1:0] <= {i == 2 || (i == 0 && (m == 1 || m == 3)), i == 0};
        settle();
        apb(1'b0, 8'h08, 32'h0);
        chk("sequencer", 32'(i < 2), 32'(rdv[2]));
        chk("odd table", 32'(per_lv[1]), 32'(event_out[1]));
      end
    end
    per_lv[1:0] <= 2'b01;
    settle();
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("sequencer clear", 32'h0, 32'(rdv[2]));
  endtask

  task automatic conclude();
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_lv = 6'h00;
    ev_lv = 2'h0;
    per_lv = 5'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_protect();
    t_src();
    t_truth();
    t_filt();
    t_glob();
    t_seq();
    conclude();
  end

  // Watchdog well beyond the roughly one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // custom_logic_unit_tb

// ### sim/far_side.sv
// Far-side model: pins, event lines and peripheral levels feeding the unit
`timescale 1ns/10ps
module far_side (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Levels asked for by the bench
  input  wire logic [5:0] pin_lv,
  input  wire logic [1:0] ev_lv,
  input  wire logic [4:0] per_lv,
  // Lines into the unit
  output logic      [5:0] pins,
  output logic      [1:0] events,
  output logic      [4:0] periph
);
  // Sources move just after an edge, like same-clock peripherals
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins   <= 6'h00;
      events <= 2'h0;
      periph <= 5'h00;
    end else begin
      pins   <= pin_lv;
      events <= ev_lv;
      periph <= per_lv;
    end
  end
endmodule // far_side

// ### sim/logic_unit_sva.sv
// Port-level concurrent checks of the custom logic unit
`timescale 1ns/10ps
module logic_unit_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sources
  input wire logic [5:0]  table_input_pins,
  input wire logic [1:0]  event_in,
  input wire logic [4:0]  peripheral_in,
  // Outputs
  input wire logic [1:0]  table_output_pin,
  input wire logic [1:0]  event_out
);
  logic       glob_h;
  logic [1:0] ten_h;
  logic [1:0] live_h;
  logic       acc;
  logic       wr_acc;
  logic       mapped;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Completed transfers and the decoded register space
  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign live_h = {2{glob_h}} & ten_h;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr < 8'h30) && (paddr != 8'h0c);

  // Enable bits as last written; never protected, so no lock tracking needed
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      glob_h <= 1'b0;
      ten_h  <= 2'b00;
    end else if (wr_acc) begin
      if (paddr == 8'h00) glob_h <= pwdata[0];
      if (paddr == 8'h10) ten_h[0] <= pwdata[0];
      if (paddr == 8'h20) ten_h[1] <= pwdata[0];
    end
  end

  property p_setup_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_setup_answer: assert property (p_setup_answer)
    else $error("pready not one pulse after setup");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_unmapped;
    acc && paddr >= 8'h30 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    acc && mapped |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_idle_data;
    !pready |-> prdata == 32'h0;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("prdata not zero when idle");
  property p_live;
    ((event_out | table_output_pin) & ~$past(live_h)) == 2'b00;
  endproperty
  a_live: assert property (p_live) else $error("output high on dead table");
  property p_pin_event;
    (table_output_pin & ~event_out) == 2'b00;
  endproperty
  a_pin_event: assert property (p_pin_event) else $error("pin differs from event");
  property p_global_off;
    wr_acc && paddr == 8'h00 && !pwdata[0] |-> ##2 {event_out, table_output_pin} == 4'h0;
  endproperty
  a_global_off: assert property (p_global_off) else $error("outputs live after off");
endmodule // logic_unit_sva

bind custom_logic_unit logic_unit_sva i_sva (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .table_input_pins(table_input_pins),
  .event_in(event_in), .peripheral_in(peripheral_in),
  .table_output_pin(table_output_pin), .event_out(event_out));

// ### src/custom_logic_unit.sv
// Top of the custom logic unit: APB registers, input routing, tables, outputs
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
module custom_logic_unit (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous pins and event lines
  input  wire logic [5:0]  table_input_pins,
  input  wire logic [1:0]  event_in,
  // Peripheral sources on this clock: comparator, timer A, timer B, serial, SPI
  input  wire logic [4:0]  peripheral_in,
  // Outputs
  output logic [1:0]       table_output_pin,
  output logic [1:0]       event_out
);

  localparam int NT = logic_unit_pkg::NUM_TABLES;

  logic_unit_pkg::table_cfg_s cfg [NT];
  logic [7:0]                 truth_table_byte [NT];
  logic                       global_enable;
  logic_unit_pkg::seq_mode_e  sequencer_function_select;

  logic [7:0] sync_meta;
  logic [7:0] sync_out;
  logic [5:0] pins_s;
  logic [1:0] events_s;

  logic [NT-1:0] live;
  logic [NT-1:0] tick;
  logic [NT-1:0] stage_q;
  logic [NT-1:0] final_out;
  logic [NT-1:0] alt_prev;
  logic          seq_q;

  // Bus decode
  logic        access;
  logic        wr;
  logic        hit_global;
  logic        hit_seq;
  logic        hit_status;
  logic [3:0]  page;
  logic [3:0]  word;
  logic        table_sel;
  logic        hit_table;
  logic        protect_ok;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign access     = psel & penable & pready;
  assign wr         = access & pwrite;
  assign hit_global = paddr == logic_unit_pkg::GLOBAL_CONTROL_ADDR;
  assign hit_seq    = paddr == logic_unit_pkg::SEQUENCER_CONTROL_ADDR;
  assign hit_status = paddr == logic_unit_pkg::STATUS_ADDR;
  assign page       = paddr[7:4];
  assign word       = paddr[3:0];
  assign table_sel  = page[1];
  assign hit_table  = (page == logic_unit_pkg::TABLE_FIRST_PAGE) ||
                      (page == 4'h2);
  // Pair locked while the even table's enable bit is set, even with global enable off
  assign protect_ok = ~cfg[0].enable;

  // Two flops before any logic sees a pin or event
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync_meta <= 8'h00;
      sync_out  <= 8'h00;
    end else begin
      sync_meta <= {event_in, table_input_pins};
      sync_out  <= sync_meta;
    end
  end

  assign pins_s   = sync_out[5:0];
  assign events_s = sync_out[7:6];

  // Global enable and sequencer select
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      global_enable             <= 1'b0;
      sequencer_function_select <= logic_unit_pkg::SEQ_OFF;
    end else if (wr && hit_global) begin
      global_enable <= pwdata[logic_unit_pkg::GLOBAL_ENABLE_BIT];
    end else if (wr && hit_seq && protect_ok) begin
      sequencer_function_select <= logic_unit_pkg::seq_mode_e'(
        pwdata[logic_unit_pkg::SEQ_SELECT_LSB +: 3]);
    end
  end

  // Source picker; unused codes read as low
  function automatic logic pick(input logic_unit_pkg::source_e s,
                                input logic pin, input logic link,
                                input logic feedback, input logic [1:0] ev,
                                input logic [4:0] per);
    unique case (s)
      logic_unit_pkg::SRC_FEEDBACK:   pick = feedback;
      logic_unit_pkg::SRC_LINK:       pick = link;
      logic_unit_pkg::SRC_EVENT0:     pick = ev[0];
      logic_unit_pkg::SRC_EVENT1:     pick = ev[1];
      logic_unit_pkg::SRC_PIN:        pick = pin;
      logic_unit_pkg::SRC_COMPARATOR: pick = per[0];
      logic_unit_pkg::SRC_TIMER_A:    pick = per[1];
      logic_unit_pkg::SRC_TIMER_B:    pick = per[2];
      logic_unit_pkg::SRC_SERIAL:     pick = per[3];
      logic_unit_pkg::SRC_SPI:        pick = per[4];
      default:                        pick = 1'b0; // masked input
    endcase
  endfunction

  genvar n;
  generate
    for (n = 0; n < NT; n++) begin : g_table
      logic                    sel_here;
      logic [2:0]              raw;
      logic [2:0]              table_input_vector;
      logic                    link;
      logic                    comb;
      logic_unit_pkg::source_e src [3];

      assign sel_here = hit_table && (table_sel == 1'(n));
      // Output flop of the next table avoids a combinational ring
      assign link     = event_out[(n + 1) % NT];
      assign src[0]   = cfg[n].input_source_field_zero;
      assign src[1]   = cfg[n].input_source_field_one;
      assign src[2]   = cfg[n].input_source_field_two;

      for (genvar i = 0; i < 3; i++) begin : g_in
        assign raw[i] = pick(src[i], pins_s[n * 3 + i], link, seq_q,
                             events_s, peripheral_in);
      end

      // Alternate clock is input two; it leaves the index
      assign table_input_vector = {raw[2] & ~cfg[n].clock_source_select,
                                   raw[1], raw[0]};
      assign comb = truth_table_byte[n][table_input_vector];
      assign live[n] = global_enable & cfg[n].enable;
      assign tick[n] = cfg[n].clock_source_select ?
                       (raw[2] & ~alt_prev[n]) : 1'b1;

      // Rising edges of the alternate clock become enable pulses
      always_ff @(posedge clk) begin
        if (!reset_n || !live[n])
          alt_prev[n] <= 1'b0;
        else
          alt_prev[n] <= raw[2];
      end

      // Table control and truth byte writes
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          cfg[n]              <= logic_unit_pkg::TABLE_CFG_RESET;
          truth_table_byte[n] <= logic_unit_pkg::TRUTH_RESET;
        end else if (wr && sel_here) begin
          if (word == logic_unit_pkg::CONTROL_FIRST_OFS) begin
            cfg[n].enable <= pwdata[logic_unit_pkg::TABLE_ENABLE_BIT];
            // Protected fields ride along only while the pair is idle
            if (protect_ok &&
                (pwdata[logic_unit_pkg::TABLE_ENABLE_BIT] || n != 0)) begin
              cfg[n].clock_source_select <= pwdata[logic_unit_pkg::CLOCK_SOURCE_BIT];
              cfg[n].edge_pulse_enable   <= pwdata[logic_unit_pkg::EDGE_ENABLE_BIT];
              cfg[n].pin_enable          <= pwdata[logic_unit_pkg::PIN_ENABLE_BIT];
              cfg[n].output_filter_select <= logic_unit_pkg::filter_mode_e'(
                pwdata[logic_unit_pkg::FILTER_LSB +: 2]);
            end
          end else if (word == logic_unit_pkg::CONTROL_SECOND_OFS && protect_ok) begin
            cfg[n].input_source_field_zero <= logic_unit_pkg::source_e'(
              pwdata[logic_unit_pkg::SRC0_LSB +: 4]);
            cfg[n].input_source_field_one  <= logic_unit_pkg::source_e'(
              pwdata[logic_unit_pkg::SRC1_LSB +: 4]);
          end else if (word == logic_unit_pkg::CONTROL_THIRD_OFS && protect_ok) begin
            cfg[n].input_source_field_two <= logic_unit_pkg::source_e'(
              pwdata[logic_unit_pkg::SRC2_LSB +: 4]);
          end else if (word == logic_unit_pkg::TRUTH_OFS) begin
            truth_table_byte[n] <= pwdata[7:0];
          end
        end
      end

      table_output_stage u_stage (
        .clk     (clk),
        .reset_n (reset_n),
        .enable  (live[n]),
        .tick    (tick[n]),
        .filt    (cfg[n].output_filter_select),
        .edge_en (cfg[n].edge_pulse_enable),
        .d       (comb),
        .q       (stage_q[n])
      );
    end
  endgenerate

  // Pair sequencer runs on the even table's clock
  logic_sequencer u_seq (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (~live[0]),
    .tick    (tick[0]),
    .mode    (sequencer_function_select),
    .even_in (stage_q[0]),
    .odd_in  (stage_q[1]),
    .q       (seq_q)
  );

  // Sequencer replaces the even table's output when selected
  assign final_out[0] = (sequencer_function_select == logic_unit_pkg::SEQ_OFF) ?
                        stage_q[0] : seq_q;
  assign final_out[1] = stage_q[1];

  // Outputs are flopped; no debug halt input exists here
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      table_output_pin <= 2'b00;
      event_out        <= 2'b00;
    end else begin
      event_out        <= live & final_out;
      table_output_pin <= live & final_out &
                          {cfg[1].pin_enable, cfg[0].pin_enable};
    end
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (hit_global)
      rd_word[logic_unit_pkg::GLOBAL_ENABLE_BIT] = global_enable;
    else if (hit_seq)
      rd_word[logic_unit_pkg::SEQ_SELECT_LSB +: 3] = sequencer_function_select;
    else if (hit_status)
      rd_word[2:0] = {seq_q, event_out};
    else if (hit_table) begin
      unique case (word)
        logic_unit_pkg::CONTROL_FIRST_OFS: begin
          rd_word[logic_unit_pkg::TABLE_ENABLE_BIT] = cfg[table_sel].enable;
          rd_word[logic_unit_pkg::CLOCK_SOURCE_BIT] = cfg[table_sel].clock_source_select;
          rd_word[logic_unit_pkg::EDGE_ENABLE_BIT]  = cfg[table_sel].edge_pulse_enable;
          rd_word[logic_unit_pkg::PIN_ENABLE_BIT]   = cfg[table_sel].pin_enable;
          rd_word[logic_unit_pkg::FILTER_LSB +: 2]  = cfg[table_sel].output_filter_select;
        end
        logic_unit_pkg::CONTROL_SECOND_OFS: begin
          rd_word[logic_unit_pkg::SRC0_LSB +: 4] = cfg[table_sel].input_source_field_zero;
          rd_word[logic_unit_pkg::SRC1_LSB +: 4] = cfg[table_sel].input_source_field_one;
        end
        logic_unit_pkg::CONTROL_THIRD_OFS:
          rd_word[logic_unit_pkg::SRC2_LSB +: 4] = cfg[table_sel].input_source_field_two;
        logic_unit_pkg::TRUTH_OFS:
          rd_word[7:0] = truth_table_byte[table_sel];
        default:
          rd_ok = 1'b0;
      endcase
    end else
      rd_ok = 1'b0;
  end

  // Answer prepared in setup so the first access cycle completes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      prdata  <= (psel & ~penable & ~pwrite & rd_ok) ? rd_word : 32'h0000_0000;
    end
  end

endmodule // custom_logic_unit

// ### src/logic_sequencer.sv
// Pair sequencer: gated D flip-flop, JK flip-flop, D latch or RS latch
`timescale 1ns/10ps
module logic_sequencer (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Control
  input  wire logic                      clear,
  input  wire logic                      tick,
  input  wire logic_unit_pkg::seq_mode_e mode,
  // Pair inputs
  input  wire logic                      even_in,
  input  wire logic                      odd_in,
  output logic                           q
);

  logic state;
  logic next_state;

  // Latch modes follow every cycle, flip-flop modes only on the tick
  always_comb begin
    next_state = state;
    unique case (mode)
      logic_unit_pkg::SEQ_DFF:    if (tick && odd_in) next_state = even_in;
      logic_unit_pkg::SEQ_JK: begin
        if (tick) begin
          unique case ({even_in, odd_in})
            2'b01:   next_state = 1'b0;
            2'b10:   next_state = 1'b1;
            2'b11:   next_state = ~state;
            default: next_state = state;
          endcase
        end
      end
      logic_unit_pkg::SEQ_DLATCH: if (odd_in) next_state = even_in;
      // Forbidden S and R together holds state rather than race
      logic_unit_pkg::SEQ_RS:     if (even_in != odd_in) next_state = even_in;
      default:                    next_state = 1'b0;
    endcase
  end

  // Mask gives the clear effect without waiting for an edge
  assign q = state & ~clear;

  always_ff @(posedge clk) begin
    if (!reset_n || clear)
      state <= 1'b0;
    else
      state <= next_state;
  end

endmodule // logic_sequencer

// ### src/logic_unit_pkg.sv
// Shared constants, types and register map of the custom logic unit
// Summary of operation
// - Two tables, each with filter and edge stage
// - Truth byte implements any three-input function
// - Masked input reads as constant low
// - Inputs from pins, events, neighbour, peripherals
// - Pair sequencer: DFF, JK, D latch, RS
// - Final output drives pin and event line
// - Default timing from the peripheral clock
// - Clock select one uses input two as clock
// - Alternate clock forces index bit two low
// - Sequencer follows even table's alternate clock
// - Keeps running while the processor is halted
// - Pair configuration only while even table off; truth bytes here stay writable at any time
// - Sequencer select and table controls protected, except enable bit
// - Even table's fields accepted with enable set, not cleared
// - Global enable bit switches whole unit
// - Per-table enable bit in first control
// - Three source fields in second, third control
// - Input vector indexes truth byte, bit2 highest
// - Sync delays two edges, filter four
// - Edge pulse on rise; state clears when disabled
// - Even drives D/S, odd drives G/K/R
package logic_unit_pkg;

  localparam int NUM_TABLES = 2;
  localparam int PINS_PER_TABLE = 3;
  localparam int NUM_EVENTS = 2;
  localparam int NUM_PERIPH = 5;

  // Register byte offsets
  localparam logic [7:0] GLOBAL_CONTROL_ADDR    = 8'h00;
  localparam logic [7:0] SEQUENCER_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR            = 8'h08;
  localparam logic [3:0] TABLE_FIRST_PAGE       = 4'h1;
  localparam logic [3:0] CONTROL_FIRST_OFS      = 4'h0;
  localparam logic [3:0] CONTROL_SECOND_OFS     = 4'h4;
  localparam logic [3:0] CONTROL_THIRD_OFS      = 4'h8;
  localparam logic [3:0] TRUTH_OFS              = 4'hc;

  // Field positions
  localparam int GLOBAL_ENABLE_BIT  = 0;
  localparam int TABLE_ENABLE_BIT   = 0;
  localparam int CLOCK_SOURCE_BIT   = 1;
  localparam int EDGE_ENABLE_BIT    = 3;
  localparam int FILTER_LSB         = 4;
  localparam int PIN_ENABLE_BIT     = 6;
  localparam int SRC0_LSB           = 0;
  localparam int SRC1_LSB           = 4;
  localparam int SRC2_LSB           = 0;
  localparam int SEQ_SELECT_LSB     = 0;

  // Reset values
  localparam logic [7:0] TRUTH_RESET = 8'h00;

  typedef enum logic [1:0] {
    FILTER_OFF,
    FILTER_SYNC,
    FILTER_PERSIST
  } filter_mode_e;

  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_DFF,
    SEQ_JK,
    SEQ_DLATCH,
    SEQ_RS
  } seq_mode_e;

  typedef enum logic [3:0] {
    SRC_MASK,
    SRC_FEEDBACK,
    SRC_LINK,
    SRC_EVENT0,
    SRC_EVENT1,
    SRC_PIN,
    SRC_COMPARATOR,
    SRC_TIMER_A,
    SRC_TIMER_B,
    SRC_SERIAL,
    SRC_SPI
  } source_e;

  // One table's control state
  typedef struct packed {
    logic         enable;
    logic         clock_source_select;
    logic         edge_pulse_enable;
    logic         pin_enable;
    filter_mode_e output_filter_select;
    source_e      input_source_field_two;
    source_e      input_source_field_one;
    source_e      input_source_field_zero;
  } table_cfg_s;

  localparam table_cfg_s TABLE_CFG_RESET = '0;

endpackage

// ### src/table_output_stage.sv
// Synchronizer, persistence filter and rising-edge detector of one table
`timescale 1ns/10ps
module table_output_stage (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  // Control
  input  wire logic                         enable,
  input  wire logic                         tick,
  input  wire logic_unit_pkg::filter_mode_e filt,
  input  wire logic                         edge_en,
  // Data
  input  wire logic                         d,
  output logic                              q
);

  logic [2:0] stage;
  logic       held;
  logic       prev;
  logic       filtered;
  logic       steady;

  // Held value only moves when three samples agree
  assign steady   = (stage == 3'b000) || (stage == 3'b111);
  assign filtered = (filt == logic_unit_pkg::FILTER_SYNC)    ? stage[1] :
                    (filt == logic_unit_pkg::FILTER_PERSIST) ? held : d;
  assign q        = edge_en ? (filtered & ~prev) : filtered;

  // Disable clears all state at the next edge, whatever the tick
  always_ff @(posedge clk) begin
    if (!reset_n || !enable) begin
      stage <= 3'b000;
      held  <= 1'b0;
      prev  <= 1'b0;
    end else if (tick) begin
      stage <= {stage[1:0], d};
      if (steady)
        held <= stage[2];
      prev <= filtered;
    end
  end

endmodule // table_output_stage
